/* include/sps_pkg.sv */
// shared constants and types for the pipelined burst sram port
package sps_pkg;
  // array organisation, wide form in use
  localparam int ADDR_W = 18;
  localparam int DATA_W = 36;
  localparam int WORDS = 262144;
  // narrow organisation figures
  localparam int NARROW_ADDR_W = 19;
  localparam int NARROW_DATA_W = 18;
  localparam int NARROW_WORDS = 524288;
  // byte lanes
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam logic [LANES-1:0] ALL_LANES = 4'hf;
  localparam logic [LANES-1:0] NO_LANES = 4'h0;
  // burst counter
  localparam int CNT_W = 2;
  localparam logic [CNT_W-1:0] CNT_START = 2'h0;
  localparam logic [CNT_W-1:0] CNT_STEP = 2'h1;
  // read data buffer
  localparam int FIFO_DEPTH = 16;
  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;
  // burst sequencing states
  typedef enum logic [0:0] {
    SPS_IDLE = 1'b0,
    SPS_BURST = 1'b1
  } sps_state_t;
endpackage

/* logic/sps_sram_port.sv */
// pipelined double-cycle-deselect burst sram port with read data buffer
`timescale 1ns/1ps

module sps_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic empty
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != FULL_CNT);
  assign out_valid = (count != '0);
  assign empty = (count == '0);
  assign out_data = store[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // sps_fifo

module sps_sram_port #(
  parameter bit THREE_SELECTS = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // address and strobes
  input wire logic [sps_pkg::ADDR_W-1:0] address,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic burst_order_linear,
  // chip selects
  input wire logic pipeline_chip_select_n,
  input wire logic depth_select_high,
  input wire logic depth_select_low_n,
  // write controls
  input wire logic [sps_pkg::LANES-1:0] byte_lane_write_n,
  input wire logic byte_write_gate_n,
  input wire logic all_lanes_write_n,
  // asynchronous controls
  input wire logic output_enable_n,
  input wire logic sleep_request,
  // data pins
  input wire logic [sps_pkg::DATA_W-1:0] dq_in,
  output logic [sps_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe,
  // read data flow
  input wire logic read_drain_ready,
  output logic read_room
);
  logic [sps_pkg::DATA_W-1:0] mem [0:sps_pkg::WORDS-1];

  sps_pkg::sps_state_t state;
  sps_pkg::sps_state_t next_state;
  logic [sps_pkg::ADDR_W-1:0] base_q;
  logic [sps_pkg::CNT_W-1:0] cnt_q;
  logic beat_q;
  logic wr_q;
  logic [sps_pkg::LANES-1:0] lanes_q;
  logic [sps_pkg::DATA_W-1:0] data_q;
  logic drive1;
  logic drive2;

  logic selected;
  logic strobe_proc;
  logic strobe_ctrl;
  logic start;
  logic cont;
  logic wr_req;
  logic [sps_pkg::LANES-1:0] lanes_req;
  logic [sps_pkg::CNT_W-1:0] low_bits;
  logic [sps_pkg::ADDR_W-1:0] word_addr;
  logic rd_issue;
  logic fifo_out_valid;
  logic fifo_empty;
  logic take;
  logic [sps_pkg::DATA_W-1:0] fifo_head;

  // select and strobe decode
  always_comb begin
    selected = ~pipeline_chip_select_n & depth_select_high
      & (THREE_SELECTS ? ~depth_select_low_n : 1'b1);
    strobe_proc = ~processor_addr_strobe_n & ~pipeline_chip_select_n;
    strobe_ctrl = ~controller_addr_strobe_n;
    start = strobe_proc | strobe_ctrl;
    cont = (state == sps_pkg::SPS_BURST) & ~start;
  end

  // write control decode
  always_comb begin
    if (!all_lanes_write_n) begin
      lanes_req = sps_pkg::ALL_LANES;
    end else if (!byte_write_gate_n) begin
      lanes_req = ~byte_lane_write_n;
    end else begin
      lanes_req = sps_pkg::NO_LANES;
    end
    wr_req = (lanes_req != sps_pkg::NO_LANES) & ~strobe_proc;
  end

  // burst sequence state
  always_comb begin
    next_state = state;
    case (state)
      sps_pkg::SPS_IDLE: begin
        if (start && selected) begin
          next_state = sps_pkg::SPS_BURST;
        end
      end
      sps_pkg::SPS_BURST: begin
        if (start && !selected) begin
          next_state = sps_pkg::SPS_IDLE;
        end
      end
      default: begin
        next_state = sps_pkg::SPS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= sps_pkg::SPS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // start address and burst counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      base_q <= sps_pkg::ADDR_RST;
      cnt_q <= sps_pkg::CNT_START;
    end else if (start && selected) begin
      base_q <= address;
      cnt_q <= sps_pkg::CNT_START;
    end else if (cont && !burst_advance_n) begin
      cnt_q <= cnt_q + sps_pkg::CNT_STEP;
    end
  end

  // beat, write controls and write data capture
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      beat_q <= 1'b0;
      wr_q <= 1'b0;
      lanes_q <= sps_pkg::NO_LANES;
      data_q <= sps_pkg::DATA_RST;
    end else begin
      beat_q <= (start & selected) | cont;
      wr_q <= ((start & selected) | cont) & wr_req;
      lanes_q <= lanes_req;
      data_q <= dq_in;
    end
  end

  // beat address from counter
  always_comb begin
    if (burst_order_linear) begin
      low_bits = base_q[sps_pkg::CNT_W-1:0] + cnt_q;
    end else begin
      low_bits = base_q[sps_pkg::CNT_W-1:0] ^ cnt_q;
    end
    word_addr = {base_q[sps_pkg::ADDR_W-1:sps_pkg::CNT_W], low_bits};
  end

  // self-timed array write by lane
  always_ff @(posedge clk) begin
    if (wr_q) begin
      for (int i = 0; i < sps_pkg::LANES; i++) begin
        if (lanes_q[i]) begin
          mem[word_addr][i*sps_pkg::LANE_W +: sps_pkg::LANE_W] <=
            data_q[i*sps_pkg::LANE_W +: sps_pkg::LANE_W];
        end
      end
    end
  end

  assign rd_issue = beat_q & ~wr_q;

  // read data buffer between array and output register
  sps_fifo #(
    .WIDTH(sps_pkg::DATA_W),
    .DEPTH(sps_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(rd_issue),
    .in_ready(read_room),
    .in_data(mem[word_addr]),
    .out_valid(fifo_out_valid),
    .out_ready(read_drain_ready),
    .out_data(fifo_head),
    .empty(fifo_empty)
  );

  assign take = fifo_out_valid & read_drain_ready;

  // output register and double-cycle deselect enable pipe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dq_out <= sps_pkg::DATA_RST;
      drive1 <= 1'b0;
      drive2 <= 1'b0;
    end else begin
      if (take) begin
        dq_out <= fifo_head;
      end
      drive1 <= take;
      drive2 <= drive1;
    end
  end

  // drivers gated without the clock
  assign dq_oe = (drive1 | drive2) & ~output_enable_n & ~sleep_request;

  // checks
  capture_on_strobe_a: assert property (@(posedge clk) disable iff (!nrst)
    (start && selected) |=> (base_q == $past(address) && cnt_q == sps_pkg::CNT_START))
    else $error("address not captured on strobe");

  advance_steps_a: assert property (@(posedge clk) disable iff (!nrst)
    (cont && !burst_advance_n) |=> (cnt_q == $past(cnt_q) + sps_pkg::CNT_STEP))
    else $error("burst counter did not step");

  hold_location_a: assert property (@(posedge clk) disable iff (!nrst)
    (cont && burst_advance_n) |=> ($stable(cnt_q) && $stable(base_q) && beat_q))
    else $error("burst location not held");

  linear_order_a: assert property (@(posedge clk) disable iff (!nrst)
    (beat_q && burst_order_linear) |-> (low_bits == base_q[1:0] + cnt_q))
    else $error("linear order wrong");

  interleave_order_a: assert property (@(posedge clk) disable iff (!nrst)
    (beat_q && !burst_order_linear) |-> (low_bits == (base_q[1:0] ^ cnt_q)))
    else $error("interleaved order wrong");

  global_write_a: assert property (@(posedge clk) disable iff (!nrst)
    (!all_lanes_write_n) |=> (lanes_q == sps_pkg::ALL_LANES))
    else $error("global write missed lanes");

  byte_lanes_a: assert property (@(posedge clk) disable iff (!nrst)
    (all_lanes_write_n && !byte_write_gate_n) |=> (lanes_q == ~$past(byte_lane_write_n)))
    else $error("byte lane write mismatch");

  deselect_extra_a: assert property (@(posedge clk) disable iff (!nrst)
    (drive1 ##1 !drive1) |-> drive2)
    else $error("drivers not held one extra cycle");

  read_latency_a: assert property (@(posedge clk) disable iff (!nrst)
    (rd_issue && fifo_empty) ##1 read_drain_ready |=> drive1)
    else $error("read data not pipelined on time");

  async_enable_a: assert property (@(posedge clk) disable iff (!nrst)
    (output_enable_n || sleep_request) |-> !dq_oe)
    else $error("drivers on while disabled");

  write_self_timed_a: assert property (@(posedge clk) disable iff (!nrst)
    (start && selected && wr_req) |=> (wr_q && data_q == $past(dq_in)))
    else $error("write not registered");

  deselect_ends_a: assert property (@(posedge clk) disable iff (!nrst)
    (start && !selected) |=> (state == sps_pkg::SPS_IDLE && !beat_q))
    else $error("deselect did not end burst");

  burst_four_c: cover property (@(posedge clk) disable iff (!nrst)
    (start && selected && !wr_req) ##1 (cont && !burst_advance_n) [*3]);

  write_beat_c: cover property (@(posedge clk) disable iff (!nrst)
    wr_q && lanes_q != sps_pkg::ALL_LANES);

  deselect_c: cover property (@(posedge clk) disable iff (!nrst)
    (state == sps_pkg::SPS_BURST) && start && !selected);

  buffer_full_c: cover property (@(posedge clk) disable iff (!nrst)
    !read_room);
endmodule // sps_sram_port

/* bench/sps_host_model.sv */
// host-side data bus model for the burst sram port
`timescale 1ns/1ps
module sps_host_model (
  // clock
  input wire logic clk,
  // device side
  input wire logic [35:0] dq_out,
  input wire logic dq_oe,
  // host side
  input wire logic host_drive,
  input wire logic [35:0] host_data,
  // resolved bus level
  output logic [35:0] dq_wire
);
  logic [35:0] last = 36'h0;
  // a released bus flips every cycle
  always @(posedge clk) begin
    last <= dq_wire;
  end
  assign dq_wire = dq_oe ? dq_out : (host_drive ? host_data : ~last);
endmodule // sps_host_model

/* bench/testbench.sv */
// self-checking bench for the pipelined burst sram port
`timescale 1ns/1ps
module testbench;
  logic clk, nrst, processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n, burst_order_linear;
  logic pipeline_chip_select_n, depth_select_high, depth_select_low_n, byte_write_gate_n, all_lanes_write_n;
  logic output_enable_n, sleep_request, read_drain_ready, host_drive, dq_oe, read_room;
  logic [3:0] byte_lane_write_n;
  logic [17:0] address, base;
  logic [35:0] dq_in, dq_out, host_data;
  logic [35:0] exp_word [4];
  logic [35:0] mem_model [logic [17:0]];
  logic [31:0] seed = 32'hb3f93502;
  int bad_count, samples_checked;

  sps_sram_port #(.THREE_SELECTS(1'b1)) u_sps_sram_port (
    .clk(clk), .nrst(nrst), .address(address), .processor_addr_strobe_n(processor_addr_strobe_n),
    .controller_addr_strobe_n(controller_addr_strobe_n), .burst_advance_n(burst_advance_n),
    .burst_order_linear(burst_order_linear), .pipeline_chip_select_n(pipeline_chip_select_n),
    .depth_select_high(depth_select_high), .depth_select_low_n(depth_select_low_n),
    .byte_lane_write_n(byte_lane_write_n), .byte_write_gate_n(byte_write_gate_n),
    .all_lanes_write_n(all_lanes_write_n), .output_enable_n(output_enable_n), .sleep_request(sleep_request),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .read_drain_ready(read_drain_ready), .read_room(read_room)
  );
  sps_host_model u_sps_host_model (
    .clk(clk), .dq_out(dq_out), .dq_oe(dq_oe), .host_drive(host_drive), .host_data(host_data), .dq_wire(dq_in)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function logic [35:0] rnd36();
    logic [31:0] h;
    h = rnd();
    return {h[3:0], rnd()};
  endfunction

  function logic [35:0] merge(logic [35:0] old, logic [35:0] d, logic g_n, logic [3:0] l_n);
    merge = old;
    for (int i = 0; i < 4; i++) if (!g_n || !l_n[i]) merge[9*i +: 9] = d[9*i +: 9];
  endfunction

  function logic [17:0] beat_addr(logic [17:0] b, logic [1:0] c, logic lin);
    return {b[17:2], lin ? b[1:0] + c : b[1:0] ^ c};
  endfunction

  task check(logic [35:0] got, logic [35:0] exp, string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // c = {ctrl strobe, proc strobe, advance, pipeline select}, all active low
  task drive(logic [3:0] c, logic g_n, logic [3:0] l_n);
    @(posedge clk);
    {controller_addr_strobe_n, processor_addr_strobe_n, burst_advance_n, pipeline_chip_select_n} <= c;
    all_lanes_write_n <= g_n;
    byte_lane_write_n <= l_n;
    byte_write_gate_n <= &l_n;
    host_drive <= !(g_n && &l_n);
  endtask

  task wr(logic [17:0] a, logic [35:0] d, logic g_n, logic [3:0] l_n);
    address <= a;
    host_data <= d;
    drive(4'h6, g_n, l_n);
    mem_model[a] = merge(mem_model.exists(a) ? mem_model[a] : 36'h0, d, g_n, l_n);
    drive(4'h7, 1'b1, 4'hf);
    drive(4'he, 1'b1, 4'hf);
  endtask

  task rd(logic [17:0] a, int n, logic [3:0] adv_n, logic lin, logic use_p, int gate);
    logic [1:0] cnt;
    cnt = 2'h0;
    address <= a;
    burst_order_linear <= lin;
    for (int t = 0; t <= n + 4; t++) begin
      if (t == 0) drive({use_p, !use_p, 2'h2}, 1'b1, 4'hf);
      else if (t < n) drive({2'h3, adv_n[t], 1'b0}, 1'b1, 4'hf);
      else if (t == n) drive(4'h7, 1'b1, 4'hf);
      else drive(4'he, 1'b1, 4'hf);
      if (t == 4 && gate == 1) output_enable_n <= 1'b1;
      if (t == 4 && gate == 2) sleep_request <= 1'b1;
      if (t > 0 && t < n && !adv_n[t]) cnt++;
      if (t < n) exp_word[t] = mem_model[beat_addr(a, cnt, lin)];
      @(negedge clk);
      if (t >= 3 && t < n + 3) check(dq_out, exp_word[t-3], "read word");
      if (t >= 2) check(36'(dq_oe), 36'(t >= 3 && t <= n + 3 && !(gate != 0 && t >= 4)), "drive enable");
    end
    @(posedge clk);
    output_enable_n <= 1'b0;
    sleep_request <= 1'b0;
  endtask

  task nosel();
    for (int v = 0; v < 3; v++) begin
      @(posedge clk);
      depth_select_high <= (v != 1);
      depth_select_low_n <= (v == 2);
      drive((v == 0) ? 4'hb : 4'h6, 1'b1, 4'hf);
      drive(4'he, 1'b1, 4'hf);
      depth_select_high <= 1'b1;
      depth_select_low_n <= 1'b0;
      repeat (5) begin
        @(negedge clk);
        check(36'(dq_oe), 36'h0, "unselected");
      end
    end
  endtask

  task stall(logic [17:0] a);
    int i;
    @(posedge clk);
    address <= a;
    read_drain_ready <= 1'b0;
    drive(4'h6, 1'b1, 4'hf);
    for (i = 1; i < 24; i++) begin
      drive(4'he, 1'b1, 4'hf);
      @(negedge clk);
      if (read_room === 1'b0) break;
    end
    check(36'(i), 36'h11, "fill depth");
    drive(4'h7, 1'b1, 4'hf);
    drive(4'he, 1'b1, 4'hf);
    read_drain_ready <= 1'b1;
    i = 0;
    repeat (40) begin
      @(negedge clk);
      if (dq_oe === 1'b1) begin
        i++;
        check(dq_out, mem_model[a], "drained word");
      end
    end
    check(36'(i), 36'h11, "drained enable cycles");
    check(36'(read_room), 36'h1, "room after drain");
    check(36'(dq_oe), 36'h0, "bus released");
  endtask

  task end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    bad_count++;
    end_of_test();
  end

  initial begin
    nrst = 1'b0;
    {controller_addr_strobe_n, processor_addr_strobe_n, burst_advance_n, pipeline_chip_select_n} = 4'he;
    {depth_select_high, depth_select_low_n, byte_write_gate_n, all_lanes_write_n} = 4'hb;
    {output_enable_n, sleep_request, read_drain_ready, host_drive, burst_order_linear} = 5'h04;
    byte_lane_write_n = 4'hf;
    address = 18'h0;
    host_data = 36'h0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    check(36'(dq_oe), 36'h0, "reset enable");
    check(36'(read_room), 36'h1, "reset room");
    check(dq_out, 36'h0, "reset data");
    @(posedge clk);
    nrst <= 1'b1;
    for (int r = 0; r < 8; r++) begin
      base = (r == 7) ? 18'h3fffc : 18'(rnd()) & 18'h3fffc;
      for (int k = 0; k < 4; k++) wr(base + 18'(k), rnd36(), 1'b0, 4'(rnd()));
      for (int k = 0; k < 4; k++) wr(base + 18'(k), rnd36(), 1'b1, r[0] ? 4'(rnd()) & 4'h7 : 4'(rnd()) & 4'he);
      rd(base | 18'(rnd() & 3), 4, 4'(rnd()), r[0], r[1], 0);
      rd(base + 18'h3, 4, 4'h0, 1'b1, 1'b0, 0);
      rd(base + 18'h2, (r == 4) ? 1 : 4, 4'h0, 1'b0, 1'b0, r % 3);
    end
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(negedge clk);
    check(36'(dq_oe), 36'h0, "mid reset enable");
    check(36'(read_room), 36'h1, "mid reset room");
    check(dq_out, 36'h0, "mid reset data");
    @(posedge clk);
    nrst <= 1'b1;
    nosel();
    stall(base);
    end_of_test();
  end
endmodule // testbench
